// *** inc/adc_seq_pkg.sv ***
// Register map, field positions, reset values and types of the converter sequencer
package adc_seq_pkg;
  // Byte addresses
  localparam logic [4:0] ADDR_STATUS  = 5'h00;
  localparam logic [4:0] ADDR_ENABLE  = 5'h04;
  localparam logic [4:0] ADDR_MODE    = 5'h08;
  localparam logic [4:0] ADDR_TIMING  = 5'h0c;
  localparam logic [4:0] ADDR_RESULT0 = 5'h10;
  // Status fields
  localparam int EOC_BIT  = 0;
  localparam int BUSY_BIT = 1;
  localparam int OVF_BIT  = 2;
  localparam int PTR_LSB  = 4;
  // Enable control fields
  localparam int ON_BIT     = 0;
  localparam int REF_BIT    = 1;
  localparam int IRQ_EN_BIT = 2;
  // Mode control fields
  localparam int CH_LSB    = 0;
  localparam int REPEAT_MODE_BIT  = 4;
  localparam int SCAN_BIT  = 5;
  localparam int START_BIT = 7;
  // Timing control fields
  localparam int CONV_CLOCK_DIVIDER_LSB  = 0;
  localparam int DELAY_LSB = 3;
  // Reset and load values, last slot and clamp limits
  localparam logic [2:0] ENABLE_RESET = 3'h0;
  localparam logic [7:0] MODE_RESET   = 8'h00;
  localparam logic [5:0] TIMING_RESET = 6'h00;
  localparam logic [1:0] PTR_START    = 2'h3;
  localparam logic [1:0] LAST_SLOT    = 2'h3;
  localparam logic [2:0] CONV_CLOCK_DIVIDER_MAX     = 3'h5;
  localparam logic [2:0] DELAY_MAX    = 3'h6;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_CONV = 2'b10
  } seq_state_t;

  typedef struct packed {
    logic       go;
    logic [2:0] channel;
  } conv_req_t;
endpackage

// *** logic/adc_sequencer_control.sv ***
// Converter sequencer: AXI4-Lite registers, conversion timing and result buffer
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module adc_sequencer_control import adc_seq_pkg::*; #(
  parameter int ADDR_W = 8
) (
  // Clock, reset, enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Analog core
  output conv_req_t              conv_req,
  input  wire logic              conv_done,
  input  wire logic [7:0]        conv_data,
  // Reference and interrupt
  output logic                   reference_on,
  output logic                   irq
);
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [7:0]        w_byte;
  logic              w_lane0;
  logic              converter_on;
  logic              internal_reference_select;
  logic              irq_enable;
  logic [2:0]        channel_sel;
  logic              repeat_mode;
  logic              scan_mode;
  logic              start;
  logic              start_q;
  logic [2:0]        conv_clock_divider;
  logic [2:0]        delay_code;
  logic              eoc;
  logic              busy;
  logic              result_overrun_flag;
  logic [1:0]        last_result_index;
  logic [7:0]        result_registers [4];
  logic [3:0]        full;
  seq_state_t        state;
  logic [1:0]        slot;
  logic [1:0]        burst_cnt;
  logic [4:0]        div_cnt;
  logic [5:0]        dly_cnt;
  logic [7:0]        rd_byte;

  // Decode
  wire logic wr_ok  = aw_addr[ADDR_W-1:5] == '0 && aw_addr[1:0] == 2'h0;
  wire logic rd_ok  = araddr[ADDR_W-1:5] == '0 && araddr[1:0] == 2'h0;
  wire logic do_write = aw_held && w_held && !bvalid;
  wire logic wr_byte  = do_write && wr_ok && w_lane0;
  wire logic wr_stat  = wr_byte && aw_addr[4:0] == ADDR_STATUS;
  wire logic wr_en    = wr_byte && aw_addr[4:0] == ADDR_ENABLE;
  wire logic wr_mode  = wr_byte && aw_addr[4:0] == ADDR_MODE;
  wire logic wr_time  = wr_byte && aw_addr[4:0] == ADDR_TIMING;
  wire logic ar_fire  = arvalid && arready;
  wire logic res_read = ar_fire && rd_ok && araddr[4];

  // Sequencer terms
  wire logic [2:0] conv_clock_divider_eff = conv_clock_divider > CONV_CLOCK_DIVIDER_MAX ? CONV_CLOCK_DIVIDER_MAX : conv_clock_divider;
  wire logic [2:0] dly_eff  = delay_code > DELAY_MAX ? DELAY_MAX : delay_code;
  wire logic [4:0] div_top  = 5'((6'h01 << conv_clock_divider_eff) - 6'h01);
  wire logic [5:0] dly_top  = 6'((7'h01 << dly_eff) - 7'h01);
  wire logic tick       = div_cnt == div_top;
  wire logic start_rise = start && !start_q;
  wire logic done       = state == ST_CONV && conv_done;
  wire logic grp_end    = scan_mode ? burst_cnt == LAST_SLOT
                        : (repeat_mode ? slot == LAST_SLOT : 1'b1);
  wire logic stop_now   = done && (!start || (!repeat_mode && grp_end));
  wire logic hw_clear   = done && !repeat_mode && grp_end;
  wire logic eoc_set    = done && (grp_end || !start);

  // Write address hold
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
        awready <= 1'b0;
      end else if (do_write) begin
        aw_held <= 1'b0;
        awready <= 1'b1;
      end else if (!aw_held) begin
        awready <= 1'b1;
      end
    end
  end

  // Write data hold
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready  <= 1'b0;
      w_held  <= 1'b0;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (ce) begin
      if (wvalid && wready) begin
        w_held  <= 1'b1;
        w_byte  <= wdata[7:0];
        w_lane0 <= wstrb[0];
        wready  <= 1'b0;
      end else if (do_write) begin
        w_held <= 1'b0;
        wready <= 1'b1;
      end else if (!w_held) begin
        wready <= 1'b1;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (ce) begin
      if (do_write) begin
        bvalid <= 1'b1;
        bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read mux; upper bits of every register read zero
  always_comb begin
    rd_byte = 8'h00;
    if (araddr[4]) begin
      rd_byte = result_registers[araddr[3:2]];
    end else begin
      unique case (araddr[4:0])
        ADDR_STATUS: rd_byte = {2'b00, last_result_index, 1'b0,
                                result_overrun_flag, busy, eoc};
        ADDR_ENABLE: rd_byte = {5'h00, irq_enable, internal_reference_select, converter_on};
        ADDR_MODE:   rd_byte = {start, 1'b0, scan_mode, repeat_mode, 1'b0, channel_sel};
        ADDR_TIMING: rd_byte = {2'b00, delay_code, conv_clock_divider};
        default:     rd_byte = 8'h00;
      endcase
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (ce) begin
      if (ar_fire) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_ok ? {24'h000000, rd_byte} : 32'h0000_0000;
        rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end else if (!rvalid) begin
        arready <= 1'b1;
      end
    end
  end

  // Enable control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {irq_enable, internal_reference_select, converter_on} <= ENABLE_RESET;
    end else if (ce && wr_en) begin
      converter_on              <= w_byte[ON_BIT];
      internal_reference_select <= w_byte[REF_BIT];
      irq_enable                <= w_byte[IRQ_EN_BIT];
    end
  end

  // Mode control; hardware clear of start wins over a same-cycle write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {start, scan_mode, repeat_mode, channel_sel} <= {MODE_RESET[7], MODE_RESET[5:4], MODE_RESET[2:0]};
    end else if (ce) begin
      if (wr_mode) begin
        channel_sel <= w_byte[CH_LSB +: 3];
        repeat_mode <= w_byte[REPEAT_MODE_BIT];
        scan_mode   <= w_byte[SCAN_BIT];
        start       <= w_byte[START_BIT];
      end
      if (hw_clear) start <= 1'b0;
      if (!converter_on) start <= 1'b0;
    end
  end

  // Timing control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {delay_code, conv_clock_divider} <= TIMING_RESET;
    end else if (ce && wr_time) begin
      conv_clock_divider <= w_byte[CONV_CLOCK_DIVIDER_LSB +: 3];
      delay_code         <= w_byte[DELAY_LSB +: 3];
    end
  end

  // Conversion clock divider, held at zero while idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt <= 5'h00;
    end else if (ce) begin
      if (state == ST_IDLE || tick) div_cnt <= 5'h00;
      else div_cnt <= div_cnt + 5'h01;
    end
  end

  // Sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state             <= ST_IDLE;
      start_q           <= 1'b0;
      busy              <= 1'b0;
      conv_req          <= '0;
      slot              <= 2'h0;
      burst_cnt         <= 2'h0;
      dly_cnt           <= 6'h00;
      last_result_index <= 2'h0;
    end else if (ce) begin
      start_q     <= start;
      conv_req.go <= 1'b0;
      if (start_rise) last_result_index <= PTR_START;
      if (!converter_on) begin
        state <= ST_IDLE;
        busy  <= 1'b0;
      end else begin
        unique case (state)
          ST_IDLE: if (start_rise) begin
            state            <= ST_WAIT;
            slot             <= 2'h0;
            burst_cnt        <= 2'h0;
            dly_cnt          <= 6'h00;
            conv_req.channel <= channel_sel;
          end
          ST_WAIT: if (!start) begin
            state <= ST_IDLE;
          end else if (tick) begin
            if (dly_cnt == dly_top) begin
              conv_req.go <= 1'b1;
              busy        <= 1'b1;
              state       <= ST_CONV;
            end else begin
              dly_cnt <= dly_cnt + 6'h01;
            end
          end
          ST_CONV: if (done) begin
            busy              <= 1'b0;
            last_result_index <= slot;
            slot              <= slot + 2'h1;
            burst_cnt         <= burst_cnt + 2'h1;
            dly_cnt           <= 6'h00;
            // 3-bit add wraps seven to zero on its own
            if (scan_mode) conv_req.channel <= grp_end ? channel_sel : conv_req.channel + 3'h1;
            state <= stop_now ? ST_IDLE : ST_WAIT;
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // Results; contents survive disable, as software may still read them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++) result_registers[i] <= 8'h00;
    end else if (ce && done && converter_on) begin
      result_registers[slot] <= conv_data;
    end
  end

  // Flags; a hardware set wins over a same-cycle read or write clear; disable clears eoc and overrun over both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eoc                 <= 1'b0;
      result_overrun_flag <= 1'b0;
      full                <= 4'h0;
    end else if (ce) begin
      if (!converter_on) begin
        eoc                 <= 1'b0;
        result_overrun_flag <= 1'b0;
      end else begin
        if (res_read) begin
          eoc                 <= 1'b0;
          full[araddr[3:2]]   <= 1'b0;
        end
        if (wr_stat && w_byte[OVF_BIT]) result_overrun_flag <= 1'b0;
        if (done) begin
          full[slot] <= 1'b1;
          if (full[slot]) result_overrun_flag <= 1'b1;
        end
        if (eoc_set) eoc <= 1'b1;
      end
    end
  end

  // Reference power and interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reference_on <= 1'b0;
      irq          <= 1'b0;
    end else if (ce) begin
      reference_on <= converter_on && internal_reference_select;
      irq          <= irq_enable && eoc;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  sequence conv_launch;
    converter_on && state == ST_WAIT && start && tick && dly_cnt == dly_top;
  endsequence
  sequence conv_finish;
    converter_on && done;
  endsequence

  eoc_set_a:     assert property (conv_finish ##0 eoc_set |=> eoc) else $error("end flag not set");
  eoc_clear_a:   assert property (converter_on && res_read && !eoc_set |=> !eoc) else $error("end flag kept");
  busy_run_a:    assert property (conv_launch |=> busy && conv_req.go ##1 !conv_req.go) else $error("busy launch");
  overrun_set_a: assert property (conv_finish ##0 full[slot] |=> result_overrun_flag) else $error("overrun missed");
  overrun_hold_a: assert property (result_overrun_flag && converter_on && !(wr_stat && w_byte[OVF_BIT])
                                   |=> result_overrun_flag) else $error("overrun lost");
  ptr_load_a:    assert property (start_rise && state != ST_CONV |=> last_result_index == PTR_START)
                   else $error("pointer not loaded");
  disable_a:     assert property (!converter_on |=> !busy && !eoc && !start && state == ST_IDLE)
                   else $error("disable incomplete");
  ref_gate_a:    assert property (reference_on |-> $past(converter_on && internal_reference_select))
                   else $error("reference on wrongly");
  irq_level_a:   assert property (irq_enable && eoc |=> irq) else $error("irq missing");
  irq_mask_a:    assert property (!irq_enable |=> !irq) else $error("irq not masked");
  start_clear_a: assert property (conv_finish ##0 !repeat_mode && grp_end |=> !start)
                   else $error("start not cleared");
  scan_wrap_a:   assert property (conv_finish ##0 scan_mode && !grp_end && conv_req.channel == 3'h7
                                  |=> conv_req.channel == 3'h0) else $error("channel no wrap");
endmodule
`default_nettype wire

// *** test/adc_sequencer_control_bench.sv ***
// Self-checking bench for the converter sequencer: register bus, conversion sequencing and flags
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module adc_sequencer_control_bench;
  import adc_seq_pkg::*;
  localparam logic [7:0] A_ST = {3'h0, ADDR_STATUS};
  localparam logic [7:0] A_EN = {3'h0, ADDR_ENABLE};
  localparam logic [7:0] A_MD = {3'h0, ADDR_MODE};
  localparam logic [7:0] A_TM = {3'h0, ADDR_TIMING};
  localparam logic [7:0] A_R0 = {3'h0, ADDR_RESULT0};
  logic        aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, conv_done, reference_on, irq;
  logic [7:0]  awaddr, araddr, conv_data;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rr;
  conv_req_t   conv_req;
  int          fails, check_count, n;

  adc_sequencer_control i_adc_sequencer_control (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .conv_req(conv_req),
    .conv_done(conv_done), .conv_data(conv_data), .reference_on(reference_on), .irq(irq));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task results;
    if (fails == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task hang;
    fails++;
    results();
  endtask
  task settle;
    repeat (3) @(posedge aclk);
    #1;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (int i = 0; i <= 200; i++) begin
      if (i == 200) hang();
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (int i = 0; i <= 200; i++) begin
      if (i == 200) hang();
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rv = rdata; rr = rresp; rready <= 1'b0;
        break;
      end
    end
  endtask
  // Analog core side: wait for a start pulse, then answer it
  task wait_go(input logic [2:0] ch);
    for (int i = 0; i <= 6000; i++) begin
      if (i == 6000) hang();
      @(posedge aclk);
      if (conv_req.go === 1'b1) break;
    end
    `CHK("channel", ch, conv_req.channel)
  endtask
  task done(input logic [7:0] d);
    conv_data <= d; conv_done <= 1'b1;
    @(posedge aclk);
    conv_done <= 1'b0; conv_data <= ~d;
  endtask

  task t_reset;
    rd(A_ST); `CHK("status", 32'h0, rv)
    rd(A_MD); `CHK("mode", 32'h0, rv)
    rd(A_EN); `CHK("enable", 32'h0, rv)
    rd(A_TM); `CHK("timing", 32'h0, rv)
    `CHK("resp okay", RESP_OKAY, rr)
    rd(8'h20); `CHK("unmapped", RESP_SLVERR, rr)
    wr(A_ST, 8'hf3); rd(A_ST); `CHK("status ro", 32'h0, rv)
  endtask
  task t_single;
    wr(A_EN, 8'h06); settle(); `CHK("ref off", 1'b0, reference_on)
    wr(A_EN, 8'h07); settle(); `CHK("ref on", 1'b1, reference_on)
    repeat (2000) @(posedge aclk);
    wr(A_MD, 8'h85); wait_go(3'h5);
    rd(A_ST); `CHK("busy ptr", 32'h32, rv)
    done(8'ha5); settle(); `CHK("irq", 1'b1, irq)
    rd(A_ST); `CHK("eoc", 32'h01, rv)
    rd(A_MD); `CHK("start clr", 32'h05, rv)
    rd(A_R0); `CHK("result0", 32'ha5, rv)
    rd(A_ST); `CHK("eoc clr", 32'h00, rv)
    settle(); `CHK("irq low", 1'b0, irq)
  endtask
  task t_overrun;
    wr(A_EN, 8'h03);
    wr(A_MD, 8'h85); wait_go(3'h5); done(8'h11); settle();
    wr(A_MD, 8'h85); wait_go(3'h5); done(8'h22); settle();
    `CHK("irq masked", 1'b0, irq)
    rd(A_ST); `CHK("ovf set", 32'h05, rv)
    wr(A_ST, 8'h00); rd(A_ST); `CHK("ovf hold", 32'h05, rv)
    wr(A_ST, 8'h04); rd(A_ST); `CHK("ovf clr", 32'h01, rv)
    rd(A_R0); `CHK("overwrite", 32'h22, rv)
    wr(A_EN, 8'h07);
  endtask
  task t_scan;
    wr(A_MD, 8'ha6);
    for (int i = 0; i < 4; i++) begin
      // Next launch follows a completion within a cycle, so check mid-burst quiet after it
      wait_go(3'(6 + i));
      if (i > 0) begin
        `CHK("no eoc mid", 1'b0, irq)
      end
      done(8'(8'h40 + i));
    end
    settle(); rd(A_ST); `CHK("scan end", 32'h31, rv)
    rd(A_MD); `CHK("scan start", 32'h26, rv)
    for (int i = 0; i < 4; i++) begin
      rd(8'(A_R0 + 8'(4 * i))); `CHK("scan res", 32'(8'h40 + i), rv)
    end
  endtask
  task t_repeat;
    wr(A_MD, 8'h92);
    for (int i = 0; i < 4; i++) begin
      wait_go(3'h2); done(8'(8'h50 + i));
    end
    // Repeat mode has already relaunched by now, so busy stands
    settle(); rd(A_ST); `CHK("cyc eoc", 32'h33, rv)
    rd(A_MD); `CHK("start kept", 32'h92, rv)
    `CHK("channel", 3'h2, conv_req.channel)
    wr(A_MD, 8'h12); done(8'h60); settle();
    rd(A_ST); `CHK("stop eoc", 32'h05, rv)
    n = 0;
    repeat (100) begin
      @(posedge aclk);
      if (conv_req.go === 1'b1) n++;
    end
    `CHK("no restart", 0, n)
    wr(A_ST, 8'h04);
    for (int i = 0; i < 4; i++) begin
      rd(8'(A_R0 + 8'(4 * i))); `CHK("cyc res", 32'(i == 0 ? 8'h60 : 8'h50 + i), rv)
    end
  endtask
  task t_disable;
    wr(A_MD, 8'h85); wait_go(3'h5);
    wr(A_EN, 8'h06); settle(); `CHK("ref dis", 1'b0, reference_on)
    done(8'h77); settle();
    rd(A_ST); `CHK("dis flags", 32'h0, rv & 32'h07)
    rd(A_MD); `CHK("dis start", 32'h05, rv)
  endtask
  // Spacing after a completion in repeat mode is divider ratio times delay length
  task t_timing;
    logic [5:0] cfg [4];
    int         ex, ra;
    cfg = '{6'h00, 6'h05, 6'h30, 6'h1a};
    for (int k = 0; k < 4; k++) begin
      wr(A_TM, cfg[k]);
      rd(A_TM); `CHK("timing rw", 32'(cfg[k]), rv)
      ra = 1 << cfg[k][2:0];
      ex = ra * (1 << cfg[k][5:3]);
      wr(A_EN, 8'h01); wr(A_MD, 8'h90);
      wait_go(3'h0); done(8'h00);
      n = 0;
      while (conv_req.go !== 1'b1) begin
        if (n > 5000) hang();
        @(posedge aclk);
        n++;
      end
      `CHK("spacing", 1'b1, n >= ex - 1 && n <= ex + ra + 3)
      wr(A_EN, 8'h00);
    end
  endtask

  initial begin
    fails = 0; check_count = 0;
    aresetn = 1'b0; ce = 1'b1; awaddr = 8'h0; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'h1;
    wvalid = 1'b0; bready = 1'b0; araddr = 8'h0; arvalid = 1'b0; rready = 1'b0;
    conv_done = 1'b0; conv_data = 8'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_single();
    t_overrun();
    t_scan();
    t_repeat();
    t_disable();
    t_timing();
    results();
  end
endmodule
`undef CHK
`default_nettype wire
